// ==== rtl/sar_adc_pkg.sv ====
// Package with register map, field layout, timing counts and carrier types of the converter control
package sar_adc_pkg;

	// Register indices; the byte address on the bus is four times the index
	localparam logic [5:0] idx_pin_enable_low = 6'h08;
	localparam logic [5:0] idx_pin_enable_high = 6'h09;
	localparam logic [5:0] idx_control = 6'h0a;
	localparam logic [5:0] idx_channel_reference = 6'h0b;
	localparam logic [5:0] idx_result_low = 6'h0c;
	localparam logic [5:0] idx_result_high = 6'h0d;
	localparam logic [5:0] idx_irq_status = 6'h0e;

	// Control register field positions
	localparam int ctl_rate_lo_pos = 5;
	localparam int ctl_run_pos = 4;
	localparam int ctl_power_pos = 3;
	localparam int ctl_sh_lo_pos = 0;

	// Channel and reference register field positions
	localparam int ref_src_pos = 7;
	localparam int ref_level_lo_pos = 4;
	localparam int chan_lo_pos = 0;

	// Reset values
	localparam logic [7:0] rst_pin_enable_low = 8'h00;
	localparam logic [6:0] rst_pin_enable_high = 7'h00;
	localparam logic [1:0] rst_rate = 2'h0;
	localparam logic [1:0] rst_sh_len = 2'h0;
	localparam logic [2:0] rst_ref_level = 3'h0;
	localparam logic [3:0] rst_channel = 4'h0;
	localparam logic [11:0] rst_result = 12'h000;

	// Conversion clock divider terminal counts (divide value minus one)
	localparam logic [5:0] div_term_16 = 6'h0f;
	localparam logic [5:0] div_term_4 = 6'h03;
	localparam logic [5:0] div_term_64 = 6'h3f;
	localparam logic [5:0] div_term_1 = 6'h00;

	// Sample-and-hold lengths in conversion clock periods, minus one
	localparam logic [3:0] sh_term_2 = 4'h1;
	localparam logic [3:0] sh_term_4 = 4'h3;
	localparam logic [3:0] sh_term_8 = 4'h7;
	localparam logic [3:0] sh_term_12 = 4'hb;

	// Result width and the top bit index of the approximation
	localparam int result_width = 12;
	localparam logic [3:0] top_bit = 4'hb;

	// Core vector for the conversion-complete interrupt
	localparam logic [7:0] done_vector = 8'h1b;

	// Converter sequence
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_sample = 2'b01,
		st_convert = 2'b11,
		st_done = 2'b10
	} conv_state_t;

	// Everything handed to the analog front end
	typedef struct packed {
		logic [14:0] pin_enable;
		logic [3:0] channel;
		logic reference_source_select;
		logic [2:0] reference_level;
		logic powered;
		logic sampling;
		logic [11:0] trial_code;
	} analog_ctrl_t;

	// Events and status toward the core
	typedef struct packed {
		logic conversion_done;
		logic irq_request;
		logic [7:0] irq_vector;
		logic wake_request;
		logic busy;
	} core_event_t;

endpackage

// ==== rtl/conv_clock_divider.sv ====
// Conversion clock tick generator: divides the main clock or follows the sub-oscillator
`timescale 1ns/1ps
module conv_clock_divider (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [1:0] rate,
	input wire logic green_mode,
	input wire logic sub_edge,
	output logic tick
);

	typedef struct packed {
		logic [5:0] count;
	} div_state_t;

	div_state_t st_ff;
	div_state_t nxt_st;
	logic [5:0] term;

	// Terminal count per rate code
	always_comb begin
		unique case (rate)
			2'b00: term = sar_adc_pkg::div_term_16;
			2'b01: term = sar_adc_pkg::div_term_4;
			2'b10: term = sar_adc_pkg::div_term_64;
			2'b11: term = sar_adc_pkg::div_term_1;
		endcase
	end

	// Count restarts while idle so every conversion outside green mode sees whole periods
	always_comb begin
		nxt_st = st_ff;
		tick = 1'b0;
		if (!run) begin
			nxt_st.count = 6'h00;
		end else if (green_mode) begin
			nxt_st.count = 6'h00;
			tick = sub_edge;
		end else if (st_ff.count >= term) begin
			nxt_st.count = 6'h00;
			tick = 1'b1;
		end else begin
			nxt_st.count = st_ff.count + 6'h01;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

endmodule

// ==== rtl/sar_adc_control.sv ====
// Control, register file and successive-approximation sequencer of the 12-bit converter
//
// Behaviour
// - Low pin-select bit n turns its pin into analog channel n, 0 to 7.
// - High pin-select bits 0-6 enable channels 8-14; bit 7 reads zero.
// - Control register bits 7 and 2 always read zero.
// - Rate field divides main clock by 16, 4, 64, 1; green mode uses sub-oscillator.
// - Software writes 1 to the run bit; the device then starts converting.
// - Device clears run bit at completion; writing zero to it does nothing.
// - Power bit zero keeps converter powered down; one lets it operate.
// - Sample-and-hold field gives 2, 4, 8 or 12 conversion clock periods.
// - Reference source bit selects internal reference at 0, external pin at 1; default 0.
// - Internal level field: supply, 4.0, 3.0, 2.5 V, or 2.0 V when top bit set.
// - Channel field routes channels 0-14; code 1111 routes half supply.
// - Twelve-bit successive approximation; each result lands in low and high registers.
// - Low result register shows bits 7 to 0, read-only.
// - High result register shows bits 11 to 4, read-only.
// - Conversion runs through sleep; completion wakes if enabled, else shuts converter off.
// - Enabled completion sends the core to the conversion-complete vector.
//
// Overview
// The block sits behind an APB slave port and holds six byte registers plus an
// interrupt enable and status word. Each register takes one aligned 32-bit word;
// only the low byte lane carries data and only the lowest strobe gates a write.
// The sequencer walks idle, sample, convert and done. A conversion starts once run
// is set while the converter is powered; it samples for the chosen number of
// conversion clock periods and then resolves one result bit per period, top first.
// The done state lasts one main clock and hands the result to the result register,
// clears run and raises the one-cycle completion pulse.
//
// Hazards and limitations
// Power loss mid-conversion drops back to idle but leaves run set, so the
// conversion restarts from sampling as soon as power returns.
// The comparator answer is taken as same-clock logic; a front end that settles
// later than one main clock needs a slower rate code.
// The sub-oscillator reaches the block as a foreign clock and is counted after a
// three-stage synchroniser, so in green mode the first period may come up to one
// sub-oscillator period late.
`timescale 1ns/1ps
module sar_adc_control #(
	parameter int addr_width = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [addr_width-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic green_mode,
	input wire logic sleep_mode,
	input wire logic sub_osc_clk,
	input wire logic comparator_high,
	output sar_adc_pkg::analog_ctrl_t analog_ctrl,
	output sar_adc_pkg::core_event_t core_event
);

	// Whole state of the block
	typedef struct packed {
		logic [7:0] pin_low;
		logic [6:0] pin_high;
		logic [1:0] rate;
		logic run;
		logic power;
		logic [1:0] sh_len;
		logic ref_src;
		logic [2:0] ref_level;
		logic [3:0] channel;
		logic irq_en;
		logic [11:0] result;
		sar_adc_pkg::conv_state_t fsm;
		logic [3:0] bit_idx;
		logic [3:0] count;
		logic [11:0] sar;
		logic shutoff;
		logic sub_s1;
		logic sub_s2;
		logic sub_s3;
		logic sub_level;
		logic done_pulse;
		logic wake_pulse;
		logic [7:0] rdata;
	} ctl_state_t;

	// Single state register and its next value; every flop of the block except the divider count is in here
	// so that reset and the clock edge are written once and cannot drift apart.
	ctl_state_t st_ff;
	ctl_state_t nxt_st;

	// Bus decode helpers
	logic [5:0] index;
	logic addr_hit;
	logic setup_phase;
	logic write_access;
	logic lane0;
	logic [7:0] wbyte;
	logic [7:0] rd_mux;
	logic sub_edge;
	logic tick;
	logic powered;
	logic [3:0] sh_term;
	logic seq_active;

	// Word index from the byte address; the two low address bits are ignored since
	// every register is one aligned word.
	// A write needs the access phase, the write direction and the low strobe.
	assign index = paddr[7:2];
	assign setup_phase = psel && !penable;
	assign write_access = psel && penable && pwrite;
	assign lane0 = pstrb[0];
	assign wbyte = pwdata[7:0];

	// Decode; bus is always ready and flags unmapped words as an error
	always_comb begin
		unique case (index)
			sar_adc_pkg::idx_pin_enable_low,
			sar_adc_pkg::idx_pin_enable_high,
			sar_adc_pkg::idx_control,
			sar_adc_pkg::idx_channel_reference,
			sar_adc_pkg::idx_result_low,
			sar_adc_pkg::idx_result_high,
			sar_adc_pkg::idx_irq_status: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	end

	// The slave never stalls: every access phase completes in one cycle.
	// Unmapped words still complete, but with the error flag and zero data.
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit;
	assign prdata = {24'h000000, st_ff.rdata};

	// Read mux; unused bits are forced low here rather than stored
	always_comb begin
		unique case (index)
			sar_adc_pkg::idx_pin_enable_low: rd_mux = st_ff.pin_low;
			sar_adc_pkg::idx_pin_enable_high: rd_mux = {1'b0, st_ff.pin_high};
			sar_adc_pkg::idx_control: rd_mux = {1'b0, st_ff.rate, st_ff.run, st_ff.power, 1'b0,
				st_ff.sh_len};
			sar_adc_pkg::idx_channel_reference: rd_mux = {st_ff.ref_src, st_ff.ref_level, st_ff.channel};
			sar_adc_pkg::idx_result_low: rd_mux = st_ff.result[7:0];
			sar_adc_pkg::idx_result_high: rd_mux = st_ff.result[11:4];
			sar_adc_pkg::idx_irq_status: rd_mux = {5'h00, st_ff.shutoff, seq_active, st_ff.irq_en};
			default: rd_mux = 8'h00;
		endcase
	end

	// Sub-oscillator is a foreign clock: counted only once two late stages agree
	assign sub_edge = (st_ff.sub_s2 == st_ff.sub_s3) && st_ff.sub_s2 && !st_ff.sub_level;

	// Sleep shutoff overrides the power bit until the core leaves sleep
	assign powered = st_ff.power && !st_ff.shutoff;
	assign seq_active = st_ff.fsm != sar_adc_pkg::st_idle;

	// Sampling length per code
	always_comb begin
		unique case (st_ff.sh_len)
			2'b00: sh_term = sar_adc_pkg::sh_term_2;
			2'b01: sh_term = sar_adc_pkg::sh_term_4;
			2'b10: sh_term = sar_adc_pkg::sh_term_8;
			2'b11: sh_term = sar_adc_pkg::sh_term_12;
		endcase
	end

	// Conversion clock ticks; the divider only counts while the sequencer is busy,
	// so outside green mode the first tick lands a whole period after the start.
	// Changing the rate mid-conversion applies to the period being counted; a count at or past the new terminal wraps at once.
	conv_clock_divider u_divider (
		.pclk(pclk),
		.presetn(presetn),
		.run(seq_active),
		.rate(st_ff.rate),
		.green_mode(green_mode),
		.sub_edge(sub_edge),
		.tick(tick)
	);

	// Next state: bus writes, sequencer and synchroniser
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done_pulse = 1'b0;
		nxt_st.wake_pulse = 1'b0;

		// Synchroniser chain and filtered sub-oscillator level
		nxt_st.sub_s1 = sub_osc_clk;
		nxt_st.sub_s2 = st_ff.sub_s1;
		nxt_st.sub_s3 = st_ff.sub_s2;
		if (st_ff.sub_s2 == st_ff.sub_s3) begin
			nxt_st.sub_level = st_ff.sub_s2;
		end

		// Read data is captured in the setup cycle so it stands through the access
		if (setup_phase) begin
			nxt_st.rdata = rd_mux;
		end

		// Leaving sleep releases the forced shutoff
		if (!sleep_mode) begin
			nxt_st.shutoff = 1'b0;
		end

		// Sequencer
		// Sample state counts conversion clock ticks up to the hold length.
		// Convert state keeps or drops the trial bit on each tick, then sets the next
		// lower bit as the new trial; after bit zero it moves to done.
		// Done state publishes the result, so a read never sees a half-built code.
		unique case (st_ff.fsm)
			sar_adc_pkg::st_idle: begin
				if (st_ff.run && powered) begin
					nxt_st.fsm = sar_adc_pkg::st_sample;
					nxt_st.count = 4'h0;
				end
			end
			sar_adc_pkg::st_sample: begin
				if (!powered) begin
					nxt_st.fsm = sar_adc_pkg::st_idle;
				end else if (tick) begin
					if (st_ff.count == sh_term) begin
						nxt_st.fsm = sar_adc_pkg::st_convert;
						nxt_st.bit_idx = sar_adc_pkg::top_bit;
						nxt_st.sar = 12'h800;
					end else begin
						nxt_st.count = st_ff.count + 4'h1;
					end
				end
			end
			sar_adc_pkg::st_convert: begin
				if (!powered) begin
					nxt_st.fsm = sar_adc_pkg::st_idle;
				end else if (tick) begin
					// Keep the trial bit only when the input is at or above the trial level
					nxt_st.sar[st_ff.bit_idx] = comparator_high;
					if (st_ff.bit_idx == 4'h0) begin
						nxt_st.fsm = sar_adc_pkg::st_done;
					end else begin
						nxt_st.bit_idx = st_ff.bit_idx - 4'h1;
						nxt_st.sar[st_ff.bit_idx - 4'h1] = 1'b1;
					end
				end
			end
			sar_adc_pkg::st_done: begin
				nxt_st.fsm = sar_adc_pkg::st_idle;
				nxt_st.result = st_ff.sar;
				nxt_st.run = 1'b0;
				nxt_st.done_pulse = 1'b1;
				if (sleep_mode && st_ff.irq_en) begin
					nxt_st.wake_pulse = 1'b1;
				end else if (sleep_mode) begin
					nxt_st.shutoff = 1'b1;
				end
			end
		endcase

		// Register writes; a run write of one wins over the clear at completion
		if (write_access && lane0) begin
			unique case (index)
				sar_adc_pkg::idx_pin_enable_low: nxt_st.pin_low = wbyte;
				sar_adc_pkg::idx_pin_enable_high: nxt_st.pin_high = wbyte[6:0];
				sar_adc_pkg::idx_control: begin
					nxt_st.rate = wbyte[sar_adc_pkg::ctl_rate_lo_pos +: 2];
					nxt_st.power = wbyte[sar_adc_pkg::ctl_power_pos];
					nxt_st.sh_len = wbyte[sar_adc_pkg::ctl_sh_lo_pos +: 2];
					if (wbyte[sar_adc_pkg::ctl_run_pos]) begin
						nxt_st.run = 1'b1;
					end
				end
				sar_adc_pkg::idx_channel_reference: begin
					nxt_st.ref_src = wbyte[sar_adc_pkg::ref_src_pos];
					nxt_st.ref_level = wbyte[sar_adc_pkg::ref_level_lo_pos +: 3];
					nxt_st.channel = wbyte[sar_adc_pkg::chan_lo_pos +: 4];
				end
				sar_adc_pkg::idx_irq_status: nxt_st.irq_en = wbyte[0];
				default: begin
				end
			endcase
		end
	end

	// State register; every field starts from a constant
	// Run, power and shutoff all reset low, so the converter is idle and powered
	// down until software configures it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
			st_ff.pin_low <= sar_adc_pkg::rst_pin_enable_low;
			st_ff.pin_high <= sar_adc_pkg::rst_pin_enable_high;
			st_ff.rate <= sar_adc_pkg::rst_rate;
			st_ff.sh_len <= sar_adc_pkg::rst_sh_len;
			st_ff.ref_src <= 1'b0;
			st_ff.ref_level <= sar_adc_pkg::rst_ref_level;
			st_ff.channel <= sar_adc_pkg::rst_channel;
			st_ff.result <= sar_adc_pkg::rst_result;
			st_ff.fsm <= sar_adc_pkg::st_idle;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Analog front end controls; trial code only moves during conversion
	always_comb begin
		analog_ctrl.pin_enable = {st_ff.pin_high, st_ff.pin_low};
		analog_ctrl.channel = st_ff.channel;
		analog_ctrl.reference_source_select = st_ff.ref_src;
		analog_ctrl.reference_level = st_ff.ref_level;
		analog_ctrl.powered = powered;
		analog_ctrl.sampling = st_ff.fsm == sar_adc_pkg::st_sample;
		analog_ctrl.trial_code = st_ff.sar;
	end

	// Core side events; the vector is offered constantly, with or without a request
	// Completion and wake are registered pulses of exactly one cycle, so the core
	// sees each conversion once regardless of how long it sleeps afterwards.
	// Busy covers sample, convert and done, and falls with the completion pulse.
	always_comb begin
		core_event.conversion_done = st_ff.done_pulse;
		core_event.irq_request = st_ff.done_pulse && st_ff.irq_en;
		core_event.irq_vector = sar_adc_pkg::done_vector;
		core_event.wake_request = st_ff.wake_pulse;
		core_event.busy = seq_active;
	end

endmodule

// ==== verification/analog_front_model.sv ====
// Behavioural analog front end and comparator facing the converter
`timescale 1ns/1ps
module analog_front_model (
	input wire logic pclk,
	input wire sar_adc_pkg::analog_ctrl_t analog_ctrl,
	input wire logic [11:0] level,
	output logic comparator_high
);
	logic toggle_ff = 1'h0;
	// An unpowered comparator gives no answer, so it shows a changing pattern
	always @(posedge pclk) toggle_ff <= ~toggle_ff;
	// Code 1111 measures half supply; every other code sees the bench level
	always_comb begin
		if (!analog_ctrl.powered) comparator_high = toggle_ff;
		else if (analog_ctrl.channel == 4'hf) comparator_high = 12'h800 >= analog_ctrl.trial_code;
		else comparator_high = level >= analog_ctrl.trial_code;
	end
endmodule

// ==== verification/sar_adc_control_properties.sv ====
// Concurrent checks on the converter control ports
`timescale 1ns/1ps
module sar_adc_control_checker #(
	parameter int addr_width = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [addr_width-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic green_mode,
	input wire logic sleep_mode,
	input wire logic sub_osc_clk,
	input wire logic comparator_high,
	input wire sar_adc_pkg::analog_ctrl_t analog_ctrl,
	input wire sar_adc_pkg::core_event_t core_event
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access phase decode shared by the bus checks
	wire acc = psel && penable;
	wire [5:0] idx = paddr[7:2];
	wire wr0 = acc && pwrite && pstrb[0];
	sequence start_s;
		$rose(core_event.busy);
	endsequence
	sequence done_s;
		core_event.conversion_done;
	endsequence
	map_error_a: assert property (acc |-> pready && pslverr == (idx < 6'h08 || idx > 6'h0e))
		else $error("bus error flag wrong");
	ctl_reserved_a: assert property (acc && !pwrite && idx == sar_adc_pkg::idx_control |-> !prdata[7] && !prdata[2])
		else $error("control spare bits set");
	pin_top_a: assert property (acc && !pwrite && idx == sar_adc_pkg::idx_pin_enable_high |-> !prdata[7])
		else $error("upper pin select bit 7 set");
	pin_low_a: assert property (wr0 && idx == sar_adc_pkg::idx_pin_enable_low |=> analog_ctrl.pin_enable[7:0] == $past(pwdata[7:0]))
		else $error("pin enables not updated");
	chan_ref_a: assert property (wr0 && idx == sar_adc_pkg::idx_channel_reference |=>
		{analog_ctrl.reference_source_select, analog_ctrl.reference_level, analog_ctrl.channel} == $past(pwdata[7:0]))
		else $error("channel or reference wrong");
	sample_min_a: assert property (start_s |-> analog_ctrl.sampling [*2])
		else $error("sample phase too short");
	done_origin_a: assert property (done_s |-> $past(core_event.busy) && !$past(analog_ctrl.sampling))
		else $error("completion without conversion");
	irq_pair_a: assert property (core_event.irq_request |-> done_s ##0 core_event.irq_vector == sar_adc_pkg::done_vector)
		else $error("interrupt without completion");
	wake_done_a: assert property (core_event.wake_request |-> core_event.conversion_done && $past(sleep_mode))
		else $error("wake outside sleep completion");
	power_idle_a: assert property (!analog_ctrl.powered [*2] |-> !core_event.busy)
		else $error("busy while powered down");
endmodule
bind sar_adc_control sar_adc_control_checker #(.addr_width(addr_width)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .green_mode(green_mode), .sleep_mode(sleep_mode), .sub_osc_clk(sub_osc_clk),
	.comparator_high(comparator_high), .analog_ctrl(analog_ctrl), .core_event(core_event));

// ==== verification/tb.sv ====
// Self-checking bench of the converter control block
`timescale 1ns/1ps
module tb;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic green_mode = 1'h0;
	logic sleep_mode = 1'h0;
	logic sub_osc_clk = 1'h0;
	logic comparator_high;
	logic [11:0] level = 12'h000;
	logic [2:0] sub_cnt = 3'h0;
	sar_adc_pkg::analog_ctrl_t analog_ctrl;
	sar_adc_pkg::core_event_t core_event;
	int err_total = 0;
	int num_checks = 0;
	logic [7:0] q;
	logic e;
	initial begin
		forever #4 pclk = ~pclk;
	end
	// Sub-oscillator stand-in, ten main cycles a period
	always @(posedge pclk) begin
		sub_cnt <= (sub_cnt == 3'h4) ? 3'h0 : sub_cnt + 3'h1;
		if (sub_cnt == 3'h4) sub_osc_clk <= ~sub_osc_clk;
	end
	sar_adc_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.green_mode(green_mode), .sleep_mode(sleep_mode), .sub_osc_clk(sub_osc_clk),
		.comparator_high(comparator_high), .analog_ctrl(analog_ctrl), .core_event(core_event));
	analog_front_model u_front (.pclk(pclk), .analog_ctrl(analog_ctrl), .level(level),
		.comparator_high(comparator_high));
	task automatic summarize;
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Releases the bus first, so waits never leave an access phase open
	task automatic cyc(input int n);
		psel <= 1'h0;
		penable <= 1'h0;
		repeat (n) @(posedge pclk);
	endtask
	// One transfer; the bus stays claimed so a next one may follow at once
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		k = 0;
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'h1 && k < 100);
		q = prdata[7:0];
		e = pslverr;
		if (k >= 100) begin
			err_total++;
			summarize();
		end
	endtask
	function automatic int dv(input logic [1:0] r);
		return (r == 2'h0) ? 16 : (r == 2'h1) ? 4 : (r == 2'h2) ? 64 : 1;
	endfunction
	function automatic int sv(input logic [1:0] s);
		return (s == 2'h3) ? 12 : 2 << s;
	endfunction
	// One conversion; mid rewrites run both ways while it is under way
	task automatic conv(input logic [1:0] rt, input logic [1:0] sh, input logic g, input logic slp,
		input logic ie, input logic mid);
		int n, d, lo;
		logic [3:0] ch;
		logic [11:0] lv, ex;
		logic irq, wk;
		ch = (rt == 2'h1) ? 4'hf : 4'($urandom);
		lv = 12'($urandom);
		ex = (ch == 4'hf) ? 12'h800 : lv;
		d = g ? 10 : dv(rt);
		lo = (sv(sh) + 12) * d;
		level <= lv;
		green_mode <= g;
		sleep_mode <= slp;
		apb(1'h1, 8'h38, {7'h0, ie});
		apb(1'h1, 8'h2c, {4'h0, ch});
		apb(1'h1, 8'h28, {1'h0, rt, 2'h3, 1'h0, sh});
		n = 0;
		irq = 1'h0;
		wk = 1'h0;
		do begin
			if (mid && n == 300) begin
				apb(1'h1, 8'h28, {1'h0, rt, 2'h3, 1'h0, sh});
				apb(1'h1, 8'h28, {1'h0, rt, 2'h1, 1'h0, sh});
				n += 4;
			end
			cyc(1);
			n++;
			irq |= core_event.irq_request;
			wk |= core_event.wake_request;
		end while (core_event.conversion_done !== 1'h1 && n < 5000);
		if (n >= 5000) begin
			err_total++;
			summarize();
		end
		chk({7'h0, n > lo - d && n <= lo + d + 8}, 8'h1);
		chk({6'h0, irq, wk}, {6'h0, ie, ie & slp});
		apb(1'h0, 8'h30, 8'h0);
		chk(q, ex[7:0]);
		apb(1'h0, 8'h34, 8'h0);
		chk(q, ex[11:4]);
		apb(1'h0, 8'h28, 8'h0);
		chk(q, {1'h0, rt, 2'h1, 1'h0, sh});
		chk({7'h0, analog_ctrl.powered}, {7'h0, !slp || ie});
		sleep_mode <= 1'h0;
		cyc(2 * d + 3);
		chk({7'h0, analog_ctrl.powered}, 8'h1);
		$display("test conversion rate %0d hold %0d done", rt, sh);
	endtask
	initial begin
		int i;
		logic [7:0] v, lo8;
		void'($urandom(32'hd9ce));
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		cyc(1);
		for (i = 8; i < 16; i++) begin
			apb(1'h0, 8'(i * 4), 8'h0);
			chk({7'h0, e}, {7'h0, i == 15});
			chk(q, 8'h0);
		end
		$display("test reset values done");
		for (i = 0; i < 16; i++) begin
			lo8 = 8'($urandom);
			v = 8'($urandom);
			apb(1'h1, 8'h20, lo8);
			apb(1'h1, 8'h24, v);
			apb(1'h1, 8'h2c, {i[3:0], i[3:0]});
			apb(1'h1, 8'h28, lo8 & 8'hef);
			apb(1'h1, 8'h30, v);
			cyc(1);
			chk(analog_ctrl.pin_enable[7:0], lo8);
			chk({1'h0, analog_ctrl.pin_enable[14:8]}, v & 8'h7f);
			chk({analog_ctrl.reference_source_select, analog_ctrl.reference_level, analog_ctrl.channel}, {i[3:0], i[3:0]});
			apb(1'h0, 8'h24, 8'h0);
			chk(q, v & 8'h7f);
			apb(1'h0, 8'h28, 8'h0);
			chk(q, lo8 & 8'h6b);
			apb(1'h0, 8'h30, 8'h0);
			chk(q, 8'h0);
		end
		pstrb <= 4'he;
		apb(1'h1, 8'h20, ~lo8);
		pstrb <= 4'hf;
		apb(1'h0, 8'h20, 8'h0);
		chk(q, lo8);
		cyc(1);
		$display("test registers done");
		for (i = 0; i < 4; i++) conv(2'(i), 2'(3 - i), 1'h0, 1'h0, i[0], i == 2);
		conv(2'h2, 2'h0, 1'h1, 1'h0, 1'h0, 1'h0);
		conv(2'h3, 2'h0, 1'h0, 1'h1, 1'h1, 1'h0);
		conv(2'h3, 2'h1, 1'h0, 1'h1, 1'h0, 1'h0);
		for (i = 0; i < 6; i++) conv(2'h3, 2'($urandom), 1'h0, 1'h0, 1'($urandom), 1'h0);
		summarize();
	end
endmodule
